// file: rtl/uec_regs.sv
// usb endpoint control and status registers with token filtering
//
// Notes on behaviour
// - toggle value bit 7 reads selected endpoint's next toggle, 1 means DATA1.
// - writing 1 to bit 6 forces selected toggle to DATA1.
// - writing 1 to bit 5 forces selected toggle to DATA0.
// - bit 4 selects IN when 1, OUT when 0.
// - endpoint number bits 2..0 valid only 0 to 5.
// - each start of frame copies frame number into read-only frame registers.
// - frame count wraps from 3FF to zero.
// - host assigned address captured into read-only function address register.
// - answer only tokens for our assigned address.
// - empty iso IN with zero-length enable sends zero-length packet.
// - empty iso IN without zero-length enable sends nothing.
// - bit 4 pairs bulk OUT 4/5, bit 3 pairs OUT 2/3.
// - bits 2,1,0 pair bulk IN 6/7, 4/5, 2/3.
// - IN endpoints 1..5 active bits gate responses; bit0 one, bits7:6 zero.
// - OUT endpoints 1..5 active bits gate responses; bit0 one, bits7:6 zero.
// - iso IN endpoint 8 active bit gates responses.
// - iso OUT endpoint 8 active bit gates responses.
// - eight bytes of latest SETUP packet held for software reads.
// - iso buffer starts hold address bits 9..4 in bits 7..2, low zero.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module uec_regs
    import uec_pkg::*;
(
    input  wire logic             i_core_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    // register port
    input  wire logic [15:0]      i_reg_addr,
    input  wire logic [7:0]       i_reg_wdata,
    input  wire logic             i_reg_wr,
    input  wire logic             i_reg_rd,
    output logic      [7:0]       o_reg_rdata,
    // usb engine events
    input  wire logic             i_sof_valid,
    input  wire logic [9:0]       i_sof_frame,
    input  wire logic             i_addr_valid,
    input  wire logic [6:0]       i_addr_value,
    input  wire logic             i_setup_valid,
    input  wire logic [63:0]      i_setup_data,
    input  wire logic             i_tog_flip,
    input  wire logic             i_tog_flip_in,
    input  wire logic [2:0]       i_tog_flip_ep,
    input  wire uec_token_s       i_token,
    input  wire logic             i_iso_in_empty,
    output uec_reply_s            o_reply,
    // configuration toward the usb engine
    output logic      [4:0]       o_pairing,
    output logic      [11:0]      o_in_toggles,
    output logic      [11:0]      o_out_toggles,
    output logic      [9:0]       o_iso_out_start,
    output logic      [9:0]       o_iso_in_start
);

    // selection and state registers
    logic        tog_dir_r;
    logic [2:0]  tog_ep_r;
    logic [5:0]  tog_in_r;
    logic [5:0]  tog_out_r;
    logic [5:0]  tog_in_nxt;
    logic [5:0]  tog_out_nxt;
    logic [9:0]  frame_r;
    logic [6:0]  fn_addr_r;
    logic        iso_zlen_r;
    logic [4:0]  pairing_r;
    logic [4:0]  in_act_r;
    logic [4:0]  out_act_r;
    logic        iso_in_act_r;
    logic        iso_out_act_r;
    logic [7:0]  setup_r [0:7];
    logic [5:0]  iso_out_buf_r;
    logic [5:0]  iso_in_buf_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    // write decode
    wire wr_tog     = i_reg_wr && (i_reg_addr == TOG_CTL_ADDR);
    wire wr_pair    = i_reg_wr && (i_reg_addr == PAIRING_ADDR);
    wire wr_in_act  = i_reg_wr && (i_reg_addr == IN_ACT_ADDR);
    wire wr_out_act = i_reg_wr && (i_reg_addr == OUT_ACT_ADDR);
    wire wr_iso_in  = i_reg_wr && (i_reg_addr == ISO_IN_ACT_ADDR);
    wire wr_iso_out = i_reg_wr && (i_reg_addr == ISO_OUT_ACT_ADDR);
    wire wr_out_buf = i_reg_wr && (i_reg_addr == ISO_OUT_BUF_ADDR);
    wire wr_in_buf  = i_reg_wr && (i_reg_addr == ISO_IN_BUF_ADDR);

    // new selection applies to same-cycle set/clear; codes above 5 are stored but set and clear nothing
    wire       sel_dir   = i_reg_wdata[TOG_DIR_BIT];
    wire [2:0] sel_ep    = i_reg_wdata[2:0];
    wire       sel_ok    = (sel_ep <= EP_MAX);
    wire       do_set    = wr_tog && sel_ok && i_reg_wdata[TOG_SET_BIT];
    wire       do_clr    = wr_tog && sel_ok && i_reg_wdata[TOG_CLR_BIT];
    wire       flip_ok   = i_tog_flip && (i_tog_flip_ep <= EP_MAX);

    // toggle next state: software force beats the engine's flip in the same cycle
    always_comb begin
        tog_in_nxt  = tog_in_r;
        tog_out_nxt = tog_out_r;
        if (flip_ok) begin
            if (i_tog_flip_in) begin
                tog_in_nxt[i_tog_flip_ep] = ~tog_in_r[i_tog_flip_ep];
            end else begin
                tog_out_nxt[i_tog_flip_ep] = ~tog_out_r[i_tog_flip_ep];
            end
        end
        // writing zeros to both leaves the toggle alone
        if (do_set || do_clr) begin
            if (sel_dir) begin
                tog_in_nxt[sel_ep] = do_set;
            end else begin
                tog_out_nxt[sel_ep] = do_set;
            end
        end
    end

    // toggle control and data toggles
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            tog_dir_r <= 1'b0;
            tog_ep_r  <= 3'h0;
            tog_in_r  <= 6'h00;
            tog_out_r <= 6'h00;
        end else if (i_clk_en) begin
            if (wr_tog) begin
                tog_dir_r <= sel_dir;
                tog_ep_r  <= sel_ep;
            end
            tog_in_r  <= tog_in_nxt;
            tog_out_r <= tog_out_nxt;
        end
    end

    // frame count and function address captured from the engine
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            frame_r   <= 10'h000;
            fn_addr_r <= 7'h00;
        end else if (i_clk_en) begin
            if (i_sof_valid) begin
                frame_r <= i_sof_frame & FRAME_MAX;
            end
            if (i_addr_valid) begin
                fn_addr_r <= i_addr_value;
            end
        end
    end

    // software writable configuration
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            iso_zlen_r    <= 1'b0;
            pairing_r     <= PAIRING_RST[4:0];
            in_act_r      <= EP_ACT_RST;
            out_act_r     <= EP_ACT_RST;
            iso_in_act_r  <= 1'b1;
            iso_out_act_r <= 1'b1;
            iso_out_buf_r <= ISO_BUF_RST;
            iso_in_buf_r  <= ISO_BUF_RST;
        end else if (i_clk_en) begin
            if (wr_pair) begin
                iso_zlen_r <= i_reg_wdata[ISO_ZLEN_BIT];
                pairing_r  <= i_reg_wdata[4:0];
            end
            if (wr_in_act)  in_act_r      <= i_reg_wdata[5:1];
            if (wr_out_act) out_act_r     <= i_reg_wdata[5:1];
            if (wr_iso_in)  iso_in_act_r  <= i_reg_wdata[0];
            if (wr_iso_out) iso_out_act_r <= i_reg_wdata[0];
            if (wr_out_buf) iso_out_buf_r <= i_reg_wdata[7:2];
            if (wr_in_buf)  iso_in_buf_r  <= i_reg_wdata[7:2];
        end
    end

    // setup buffer holds the latest setup packet, byte 0 at lowest address
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 8; i++) setup_r[i] <= 8'h00;
        end else if (i_clk_en && i_setup_valid) begin
            for (int i = 0; i < 8; i++) setup_r[i] <= i_setup_data[8*i +: 8];
        end
    end

    // read mux; set/clear and unused bits read zero, unmapped reads zero
    wire        sel_tog_val = tog_dir_r ? tog_in_r[tog_ep_r] : tog_out_r[tog_ep_r];
    wire        ep_sel_ok   = (tog_ep_r <= EP_MAX);
    wire [7:0]  tog_rd      = {ep_sel_ok & sel_tog_val, 2'b00, tog_dir_r, 1'b0, tog_ep_r};
    wire        in_setup    = (i_reg_addr[15:3] == SETUP_BUF_ADDR[15:3]);

    always_comb begin
        rdata_nxt = 8'h00;
        if (in_setup) begin
            rdata_nxt = setup_r[i_reg_addr[2:0]];
        end else begin
            case (i_reg_addr)
                TOG_CTL_ADDR:     rdata_nxt = tog_rd;
                FRAME_LO_ADDR:    rdata_nxt = frame_r[7:0];
                FRAME_HI_ADDR:    rdata_nxt = {6'h00, frame_r[9:8]};
                FN_ADDR_ADDR:     rdata_nxt = {1'b0, fn_addr_r};
                PAIRING_ADDR:     rdata_nxt = {iso_zlen_r, 2'b00, pairing_r};
                IN_ACT_ADDR:      rdata_nxt = {2'b00, in_act_r, 1'b1};
                OUT_ACT_ADDR:     rdata_nxt = {2'b00, out_act_r, 1'b1};
                ISO_IN_ACT_ADDR:  rdata_nxt = {7'h00, iso_in_act_r};
                ISO_OUT_ACT_ADDR: rdata_nxt = {7'h00, iso_out_act_r};
                ISO_OUT_BUF_ADDR: rdata_nxt = {iso_out_buf_r, 2'b00};
                ISO_IN_BUF_ADDR:  rdata_nxt = {iso_in_buf_r, 2'b00};
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rdata_r <= 8'h00;
        end else if (i_clk_en) begin
            rdata_r <= i_reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // token filtering; endpoint 0 is always active, 8 is the iso pair
    wire addr_hit = (i_token.addr == fn_addr_r);
    logic ep_active;
    always_comb begin
        case (i_token.ep)
            4'h0:                   ep_active = 1'b1;
            4'h1, 4'h2, 4'h3,
            4'h4, 4'h5:             ep_active = i_token.is_in ? in_act_r[i_token.ep[2:0] - 3'h1]
                                                              : out_act_r[i_token.ep[2:0] - 3'h1];
            4'h6, 4'h7:             ep_active = 1'b1;
            4'h8:                   ep_active = i_token.is_in ? iso_in_act_r : iso_out_act_r;
            default:                ep_active = 1'b0;
        endcase
    end
    wire iso_in_tok = i_token.is_in && (i_token.ep == 4'h8);
    wire iso_silent = iso_in_tok && i_iso_in_empty && !iso_zlen_r;

    // reply is combinational, one per token cycle; one driver for the whole struct
    wire reply_hit  = i_token.valid && addr_hit && ep_active && !iso_silent;
    wire reply_zero = reply_hit && iso_in_tok && i_iso_in_empty;
    assign o_reply  = {reply_hit, reply_zero};

    assign o_reg_rdata     = rdata_r;
    assign o_pairing       = pairing_r;
    assign o_in_toggles    = {6'h00, tog_in_r};
    assign o_out_toggles   = {6'h00, tog_out_r};
    assign o_iso_out_start = {iso_out_buf_r, 4'h0};
    assign o_iso_in_start  = {iso_in_buf_r, 4'h0};

endmodule : uec_regs

// file: rtl/uec_pkg.sv
// package for the usb endpoint control register block
package uec_pkg;
    localparam logic [15:0] TOG_CTL_ADDR    = 16'hC7D7;
    localparam logic [15:0] FRAME_LO_ADDR   = 16'hC7D8;
    localparam logic [15:0] FRAME_HI_ADDR   = 16'hC7D9;
    localparam logic [15:0] FN_ADDR_ADDR    = 16'hC7DB;
    localparam logic [15:0] PAIRING_ADDR    = 16'hC7DD;
    localparam logic [15:0] IN_ACT_ADDR     = 16'hC7DE;
    localparam logic [15:0] OUT_ACT_ADDR    = 16'hC7DF;
    localparam logic [15:0] ISO_IN_ACT_ADDR = 16'hC7E0;
    localparam logic [15:0] ISO_OUT_ACT_ADDR = 16'hC7E1;
    localparam logic [15:0] SETUP_BUF_ADDR  = 16'hC7E8;
    localparam logic [15:0] ISO_OUT_BUF_ADDR = 16'hC7F0;
    localparam logic [15:0] ISO_IN_BUF_ADDR = 16'hC7F8;
    // toggle control and zero-length enable field positions
    localparam int TOG_VALUE_BIT = 7;
    localparam int TOG_SET_BIT   = 6;
    localparam int TOG_CLR_BIT   = 5;
    localparam int TOG_DIR_BIT   = 4;
    localparam int ISO_ZLEN_BIT  = 7;
    localparam logic [2:0] EP_MAX = 3'h5;
    localparam logic [9:0] FRAME_MAX = 10'h3FF;
    // reset values
    localparam logic [7:0] PAIRING_RST = 8'h00;
    localparam logic [4:0] EP_ACT_RST  = 5'h1F;
    localparam logic [5:0] ISO_BUF_RST = 6'h00;

    // token event from the usb engine
    typedef struct packed {
        logic       valid;
        logic       is_in;
        logic [6:0] addr;
        logic [3:0] ep;
    } uec_token_s;
    // per token decision for the usb engine
    typedef struct packed {
        logic respond;
        logic zero_len;
    } uec_reply_s;
endpackage : uec_pkg

// file: dv/uec_regs_sva.sv
// concurrent checks on the endpoint control register block
`timescale 1ns/1ns
module uec_regs_sva
    import uec_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_clk_en,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_sof_valid,
    input wire logic [9:0]  i_sof_frame,
    input wire logic        i_addr_valid,
    input wire logic [6:0]  i_addr_value,
    input wire uec_token_s  i_token,
    input wire uec_reply_s  o_reply,
    input wire logic [4:0]  o_pairing,
    input wire logic [11:0] o_in_toggles,
    input wire logic [11:0] o_out_toggles,
    input wire logic [9:0]  o_iso_in_start
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic [6:0] fa_r;
    // strobes qualified by the run enable, frozen cycles do nothing
    wire rd_q = i_clk_en && i_reg_rd;
    wire wt_q = i_clk_en && i_reg_wr && i_reg_addr == TOG_CTL_ADDR;
    // shadow of the assigned address, so filtering is judged independently
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)
            fa_r <= 7'h00;
        else if (i_clk_en && i_addr_valid)
            fa_r <= i_addr_value;
    end
    set_in_a: assert property (wt_q && i_reg_wdata[6] && i_reg_wdata[4] && i_reg_wdata[2:0] <= EP_MAX
        |=> o_in_toggles[$past(i_reg_wdata[2:0])]) else $error("toggle set missed");
    clr_out_a: assert property (wt_q && i_reg_wdata[6:4] == 3'b010 && i_reg_wdata[2:0] <= EP_MAX
        |=> !o_out_toggles[$past(i_reg_wdata[2:0])]) else $error("toggle clear missed");
    frame_cap_a: assert property (i_clk_en && i_sof_valid ##1 !i_sof_valid ##1 rd_q && i_reg_addr == FRAME_LO_ADDR
        |=> o_reg_rdata == $past(i_sof_frame[7:0], 3)) else $error("frame not captured");
    fn_addr_a: assert property (i_clk_en && i_addr_valid ##1 !i_addr_valid ##1 rd_q && i_reg_addr == FN_ADDR_ADDR
        |=> o_reg_rdata == {1'b0, $past(i_addr_value, 3)}) else $error("address not captured");
    addr_filter_a: assert property (i_token.valid && i_token.addr != fa_r |-> !o_reply.respond)
        else $error("foreign token answered");
    pair_cfg_a: assert property (i_clk_en && i_reg_wr && i_reg_addr == PAIRING_ADDR
        |=> o_pairing == $past(i_reg_wdata[4:0])) else $error("pairing not applied");
    in_fixed_a: assert property (rd_q && i_reg_addr == IN_ACT_ADDR
        |=> o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[0]) else $error("in active fixed bits");
    out_fixed_a: assert property (rd_q && i_reg_addr == OUT_ACT_ADDR
        |=> o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[0]) else $error("out active fixed bits");
    iso_low_a: assert property (rd_q && i_reg_addr == ISO_IN_BUF_ADDR
        |=> o_reg_rdata[1:0] == 2'b00 && o_iso_in_start[3:0] == 4'h0) else $error("iso start low bits");
endmodule : uec_regs_sva

bind uec_regs uec_regs_sva u_sva (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_sof_valid(i_sof_valid), .i_sof_frame(i_sof_frame),
    .i_addr_valid(i_addr_valid), .i_addr_value(i_addr_value), .i_token(i_token), .o_reply(o_reply),
    .o_pairing(o_pairing), .o_in_toggles(o_in_toggles), .o_out_toggles(o_out_toggles),
    .o_iso_in_start(o_iso_in_start));

// file: dv/uec_host_model.sv
// behavioural usb host side feeding frame, address, setup and token events
`timescale 1ns/1ns
module uec_host_model
    import uec_pkg::*;
(
    input  wire logic  i_core_clk,
    output logic       o_sof_valid,
    output logic [9:0] o_sof_frame,
    output logic       o_addr_valid,
    output logic [6:0] o_addr_value,
    output logic       o_setup_valid,
    output logic [63:0] o_setup_data,
    output uec_token_s o_token
);
    initial begin
        {o_sof_valid, o_addr_valid, o_setup_valid} = 3'b000;
        {o_sof_frame, o_addr_value, o_setup_data} = '0;
        o_token = '0;
    end
    // one event pulse; k 0 frame, 1 address, 2 setup; data inverted once released
    task automatic ev(input int k, input logic [63:0] d);
        @(posedge i_core_clk);
        {o_sof_valid, o_addr_valid, o_setup_valid} <= 3'b100 >> k;
        {o_sof_frame, o_addr_value, o_setup_data} <= {d[9:0], d[6:0], d};
        @(posedge i_core_clk);
        {o_sof_valid, o_addr_valid, o_setup_valid} <= 3'b000;
        {o_sof_frame, o_addr_value, o_setup_data} <= ~{d[9:0], d[6:0], d};
    endtask : ev
    // token stays presented; reply is combinational so it is read 1 ns later
    task automatic tok(input logic i, input logic [6:0] a, input logic [3:0] e);
        @(posedge i_core_clk);
        o_token <= '{1'b1, i, a, e};
        #1;
    endtask : tok
endmodule : uec_host_model

// file: dv/tb_top.sv
// self-checking bench for the endpoint control registers
`timescale 1ns/1ns
module tb_top
    import uec_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, flip = 1'b0, empty = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00, rdat, v;
    logic [4:0]  pair;
    logic [11:0] tin, tout;
    logic [9:0]  so, si, sf;
    logic        sv, av, stv;
    logic [6:0]  aval;
    logic [63:0] sd;
    uec_token_s  tk;
    uec_reply_s  rep;
    int err_total = 0, cmp_count = 0;
    logic [15:0] ra [7] = '{TOG_CTL_ADDR, PAIRING_ADDR, IN_ACT_ADDR, OUT_ACT_ADDR, ISO_IN_ACT_ADDR,
        ISO_OUT_BUF_ADDR, FRAME_LO_ADDR};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h3F, 8'h3F, 8'h01, 8'h00, 8'h00};
    always #5 clk = ~clk;
    uec_regs dut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_sof_valid(sv), .i_sof_frame(sf),
        .i_addr_valid(av), .i_addr_value(aval), .i_setup_valid(stv), .i_setup_data(sd), .i_tog_flip(flip),
        .i_tog_flip_in(1'b1), .i_tog_flip_ep(3'h2), .i_token(tk), .i_iso_in_empty(empty), .o_reply(rep),
        .o_pairing(pair), .o_in_toggles(tin), .o_out_toggles(tout), .o_iso_out_start(so), .o_iso_in_start(si));
    uec_host_model host (.i_core_clk(clk), .o_sof_valid(sv), .o_sof_frame(sf), .o_addr_valid(av),
        .o_addr_value(aval), .o_setup_valid(stv), .o_setup_data(sd), .o_token(tk));
    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, addr, wd} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, 24'(e), 24'(rdat));
    endtask : rdc
    task automatic tkc(input logic i, input logic [3:0] e, input logic [1:0] x);
        host.tok(i, 7'h7F, e);
        chk("reply", 24'(x), 24'(rep));
    endtask : tkc
    // hang guard counts as a failure
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++)
            rdc(ra[k], rv[k], "reset");
        // select is always written before the toggle is read back
        for (int d = 0; d < 2; d++)
            for (int e = 0; e < 6; e++) begin
                v = {3'b000, d[0], 1'b0, e[2:0]};
                wrr(TOG_CTL_ADDR, v | 8'h40);
                rdc(TOG_CTL_ADDR, v | 8'h80, "tog_set");
                chk("toggles", 24'h1 << (e + 12 * d), {tin, tout});
                wrr(TOG_CTL_ADDR, v);
                rdc(TOG_CTL_ADDR, v | 8'h80, "tog_keep");
                wrr(TOG_CTL_ADDR, v | 8'h20);
                rdc(TOG_CTL_ADDR, v, "tog_clr");
            end
        @(posedge clk) flip <= 1'b1;
        @(posedge clk) flip <= 1'b0;
        wrr(TOG_CTL_ADDR, 8'h12);
        rdc(TOG_CTL_ADDR, 8'h92, "tog_flip");
        wrr(TOG_CTL_ADDR, 8'h56);
        rdc(TOG_CTL_ADDR, 8'h16, "tog_bad_ep");
        host.ev(0, 64'h3FF);
        rdc(FRAME_LO_ADDR, 8'hFF, "frame_lo");
        rdc(FRAME_HI_ADDR, 8'h03, "frame_hi");
        host.ev(0, 64'h0);
        rdc(FRAME_HI_ADDR, 8'h00, "frame_wrap");
        wrr(FN_ADDR_ADDR, 8'h11);
        host.ev(1, 64'h7F);
        rdc(FN_ADDR_ADDR, 8'h7F, "fn_addr");
        rdc(16'hC7DA, 8'h00, "unmapped");
        host.ev(2, 64'h8877665544332211);
        for (int k = 0; k < 8; k++)
            rdc(SETUP_BUF_ADDR + 16'(k), 8'(8'h11 * (k + 1)), "setup");
        wrr(PAIRING_ADDR, 8'h9F);
        rdc(PAIRING_ADDR, 8'h9F, "pairing");
        chk("pair_out", 24'h1F, 24'(pair));
        tkc(1'b1, 4'h8, 2'b11);
        host.tok(1'b1, 7'h7E, 4'h8);
        chk("foreign", 24'h0, 24'(rep));
        wrr(PAIRING_ADDR, 8'h1F);
        tkc(1'b1, 4'h8, 2'b00);
        wrr(IN_ACT_ADDR, 8'h00);
        rdc(IN_ACT_ADDR, 8'h01, "in_act");
        tkc(1'b1, 4'h3, 2'b00);
        wrr(IN_ACT_ADDR, 8'hFF);
        tkc(1'b1, 4'h3, 2'b10);
        wrr(OUT_ACT_ADDR, 8'h00);
        rdc(OUT_ACT_ADDR, 8'h01, "out_act");
        tkc(1'b0, 4'h2, 2'b00);
        @(posedge clk) empty <= 1'b0;
        wrr(ISO_IN_ACT_ADDR, 8'h00);
        tkc(1'b1, 4'h8, 2'b00);
        wrr(ISO_IN_ACT_ADDR, 8'h01);
        tkc(1'b1, 4'h8, 2'b10);
        wrr(ISO_OUT_ACT_ADDR, 8'h00);
        tkc(1'b0, 4'h8, 2'b00);
        wrr(ISO_IN_BUF_ADDR, 8'hFF);
        rdc(ISO_IN_BUF_ADDR, 8'hFC, "iso_in_buf");
        wrr(ISO_OUT_BUF_ADDR, 8'hA5);
        rdc(ISO_OUT_BUF_ADDR, 8'hA4, "iso_out_buf");
        chk("iso_starts", {4'h0, 10'h290, 10'h3F0}, {4'h0, so, si});
        end_sim();
    end
endmodule : tb_top
